// ### fan_monitor.sv
`include "fan_monitor_cfg.svh"
// Overview of operation
// - start monitoring once core voltage powers up
// - else start monitoring once first addressed transaction ends or a byte is written
// - full fan speed if unaddressed 4.6 s
// - no core voltage: no timeout; write restores normal
// - programming always accepted, even after fail-safe
// - over temperature limit forces full fan speed
// - drive bit clear: fast 22.5 kHz drive
// - drive bit set: slow 10-100 Hz drive
// - range bit clear selects legacy two's complement range
// - extended range -64..191, bias 64, default
// - temperature offset +-64 C, half-degree steps
// - automatic duty capped at programmed maximum
// - bit 2 sets general pin direction
// - bit 3 sets general pin polarity
// - status bit 5 reports shared pin state in overtemp and general pin roles, fan4 fault in fan4 role, 0 in alert role
// - shared pin takes one of four roles
// - alert role: open-drain out-of-limit output
// - answer only the fixed address 2E
// - all configuration goes through the serial bus
// - xor test mode routes tree to first drive
// - first write byte loads the address pointer
module fan_monitor
	import fan_monitor_pkg::*;
#(
	parameter int FS_CYCLES = `FAILSAFE_CYCLES, // fail-safe wait, shorten in simulation
	parameter int SLOW_ACC_LIMIT = `SLOW_ACC_LIMIT // slow drive base divider
)
(
	// clock and reset
	input wire logic CLK,
	input wire logic RSTN,
	input wire logic CE,
	// serial bus pins
	input wire logic SCL,
	input wire logic SDA_I,
	output logic SDA_O,
	output logic SDA_OE,
	// supply and measurement
	input wire logic CPU_CORE_VOLTAGE_INPUT,
	input wire logic [9:0] TEMP_IN,
	input wire logic [23:0] DUTY_REQ,
	input wire logic ALERT_REQ,
	input wire logic FAN4_FAULT,
	input wire logic XOR_TREE_OUTPUT,
	// fan drives, bit 0 is the first drive
	output logic [2:0] FAN_DRIVE,
	output logic FAST_FAN_DRIVE,
	// shared pin
	input wire logic MF_PIN_I,
	output logic MF_PIN_O,
	output logic MF_PIN_OE,
	output logic OVERTEMPERATURE_PIN_ASSERTED,
	output logic FAN4_SPEED_INPUT,
	// status
	output logic MONITOR_EN,
	output logic FAILSAFE,
	output logic [7:0] TEMP_CODE
);
	ctrl_regs_t c_r; // all block state
	ctrl_regs_t c_nxt; // next state
	smb_if bus(); // slave to register file
	logic [10:0] corr; // corrected temperature, half degrees
	logic [9:0] deg; // whole degrees, signed
	logic [9:0] biased; // degrees plus extended bias
	logic [7:0] code; // reading in the selected format
	logic over_now; // reading above the limit
	logic full; // fail-safe or over-temperature full speed request
	logic tick; // one drive counter step
	logic [17:0] acc_sum; // slow accumulator trial sum
	logic [3:0] mult; // slow frequency multiple of 10 Hz
	logic [7:0] duty_eff [3]; // duty after cap and override
	logic [2:0] fan_nxt; // per channel drive level
	logic gpio_lvl; // general pin wanted level
	logic [1:0] pinf; // shared pin role
	logic [7:0] status2; // composed status byte

	smb_slave u_slave (
		.clk(CLK),
		.rstn(RSTN),
		.ce(CE),
		.scl(SCL),
		.sda_i(SDA_I),
		.sda_oe(SDA_OE),
		.bus(bus.slave)
	);
	assign SDA_O = 1'b0;

	////////////////////////////////////////////////////////////////////////////
	// temperature conversion, offset applied before formatting
	always_comb
	begin
		corr = {TEMP_IN[9], TEMP_IN} + {{3{c_r.temp_offset[7]}}, c_r.temp_offset};
		deg = corr[10:1];
		biased = deg + `TEMP_BIAS;
		if (c_r.ext_cfg[`EXT_RANGE_BIT])
		begin
			// extended: unsigned code with bias 64, clamped
			if (biased[9])
				code = 8'h00;
			else if (biased[8])
				code = 8'hFF;
			else
				code = biased[7:0];
		end
		else
		begin
			// legacy: two's complement clamped to +-127
			if ($signed(deg) > $signed(10'h07F))
				code = 8'h7F;
			else if ($signed(deg) < $signed(10'h381))
				code = 8'h81;
			else
				code = deg[7:0];
		end
		// compare in the same format as the limit register
		if (c_r.ext_cfg[`EXT_RANGE_BIT])
			over_now = c_r.temp_code > c_r.overtemp_lim;
		else
			over_now = $signed(c_r.temp_code) > $signed(c_r.overtemp_lim);
	end

	// drive counter step rate
	always_comb
	begin
		if (c_r.slow_freq[3:0] == 4'h0)
			mult = 4'h1;
		else if (c_r.slow_freq[3:0] > `SLOW_MULT_MAX)
			mult = `SLOW_MULT_MAX;
		else
			mult = c_r.slow_freq[3:0];
		acc_sum = {1'b0, c_r.slow_acc} + {14'h0000, mult};
		if (c_r.ext_cfg[`EXT_SLOW_BIT])
			tick = acc_sum >= 18'(SLOW_ACC_LIMIT);
		else
			tick = c_r.tick_cnt == 6'(`FAST_TICK_CYCLES - 1);
	end

	////////////////////////////////////////////////////////////////////////////
	// per channel duty and comparator
	assign full = c_r.st == ST_FAILSAFE || c_r.over;
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++)
		begin : g_fan
			// full speed overrides the capped loop request
			assign duty_eff[gi] = full ? `FULL_DUTY :
				(DUTY_REQ[gi*8 +: 8] > c_r.max_duty ? c_r.max_duty : DUTY_REQ[gi*8 +: 8]);
			assign fan_nxt[gi] = duty_eff[gi] == `FULL_DUTY || c_r.drv_cnt < duty_eff[gi];
		end
	endgenerate

	// shared pin pieces
	assign pinf = c_r.pin_cfg[1:0];
	assign gpio_lvl = c_r.ext_cfg[`GPIO_POL_BIT] ? c_r.test_gpio[`TEST_GPIO_OUT_BIT] :
		~c_r.test_gpio[`TEST_GPIO_OUT_BIT];

	////////////////////////////////////////////////////////////////////////////
	// main next-state process
	always_comb
	begin
		c_nxt = c_r;
		// start-up and fail-safe sequence
		case (c_r.st)
			ST_WAIT:
			begin
				if (CPU_CORE_VOLTAGE_INPUT)
				begin
					c_nxt.st = ST_TIMING;
					c_nxt.timer = 30'h0;
				end
				else if (bus.done || bus.wr_stb)
					c_nxt.st = ST_NORMAL;
			end
			ST_TIMING:
			begin
				if (bus.addr_hit)
					c_nxt.st = ST_NORMAL;
				else if (c_r.timer == 30'(FS_CYCLES - 1))
					c_nxt.st = ST_FAILSAFE;
				else
					c_nxt.timer = c_r.timer + 30'h1;
			end
			ST_NORMAL:
				c_nxt.st = ST_NORMAL;
			ST_FAILSAFE:
			begin
				// any write hands control back to the programmed settings
				if (bus.wr_stb)
					c_nxt.st = ST_NORMAL;
			end
			default:
				c_nxt.st = ST_WAIT;
		endcase
		// register writes, effective next cycle
		if (bus.wr_stb)
		begin
			case (bus.wr_addr)
				`REG_EXT_CFG: c_nxt.ext_cfg = bus.wr_data;
				`REG_PIN_CFG: c_nxt.pin_cfg = bus.wr_data;
				`REG_TEMP_OFFSET: c_nxt.temp_offset = bus.wr_data;
				`REG_MAX_DUTY: c_nxt.max_duty = bus.wr_data;
				`REG_OVERTEMP_LIM: c_nxt.overtemp_lim = bus.wr_data;
				`REG_SLOW_FREQ: c_nxt.slow_freq = bus.wr_data;
				`REG_TEST_GPIO: c_nxt.test_gpio = bus.wr_data;
				default: c_nxt.ext_cfg = c_r.ext_cfg; // read-only or unmapped
			endcase
		end
		// measurement only while monitoring runs
		if (c_r.st != ST_WAIT)
		begin
			c_nxt.temp_code = code;
			c_nxt.over = over_now;
		end
		// drive counter
		if (c_r.ext_cfg[`EXT_SLOW_BIT])
			c_nxt.slow_acc = tick ? 17'(acc_sum - 18'(SLOW_ACC_LIMIT)) : acc_sum[16:0];
		else
			c_nxt.tick_cnt = tick ? 6'h00 : c_r.tick_cnt + 6'h01;
		if (tick)
			c_nxt.drv_cnt = c_r.drv_cnt + 8'h01;
		c_nxt.fan = fan_nxt;
		if (c_r.test_gpio[`TEST_XOR_BIT])
			c_nxt.fan[0] = XOR_TREE_OUTPUT;
		// shared pin, open drain, exactly one role
		c_nxt.ot_in = pinf == `PINF_OVERTEMP && !MF_PIN_I;
		c_nxt.f4_speed = pinf == `PINF_FAN4 ? MF_PIN_I : 1'b1;
		case (pinf)
			`PINF_ALERT:
			begin
				c_nxt.mf_oe = ALERT_REQ || c_r.over;
				c_nxt.shared_stat = 1'b0;
			end
			`PINF_OVERTEMP:
			begin
				c_nxt.mf_oe = c_r.over;
				c_nxt.shared_stat = !MF_PIN_I;
			end
			`PINF_GPIO:
			begin
				c_nxt.mf_oe = c_r.ext_cfg[`GPIO_DIR_BIT] && !gpio_lvl;
				c_nxt.shared_stat = c_r.ext_cfg[`GPIO_POL_BIT] ? MF_PIN_I : !MF_PIN_I;
			end
			default:
			begin
				c_nxt.mf_oe = 1'b0;
				c_nxt.shared_stat = FAN4_FAULT;
			end
		endcase
	end

	// state register
	always_ff @(posedge CLK or negedge RSTN)
	begin
		if (!RSTN)
			c_r <= '{st: ST_WAIT, ext_cfg: `EXT_CFG_RST, pin_cfg: `PIN_CFG_RST,
				temp_offset: `TEMP_OFFSET_RST, max_duty: `MAX_DUTY_RST,
				overtemp_lim: `OVERTEMP_LIM_RST, slow_freq: `SLOW_FREQ_RST,
				test_gpio: `TEST_GPIO_RST, f4_speed: 1'b1, default: '0};
		else if (CE)
			c_r <= c_nxt;
	end

	////////////////////////////////////////////////////////////////////////////
	// register read mux
	always_comb
	begin
		status2 = 8'h00;
		status2[`STAT2_FAILSAFE_BIT] = c_r.st == ST_FAILSAFE;
		status2[`STAT2_OVERTEMP_BIT] = c_r.over;
		status2[`STAT2_MONITOR_BIT] = c_r.st != ST_WAIT;
		status2[`STAT2_SHARED_BIT] = c_r.shared_stat;
		case (bus.rd_ptr)
			`REG_EXT_CFG: bus.rd_data = c_r.ext_cfg;
			`REG_PIN_CFG: bus.rd_data = c_r.pin_cfg;
			`REG_TEMP_OFFSET: bus.rd_data = c_r.temp_offset;
			`REG_MAX_DUTY: bus.rd_data = c_r.max_duty;
			`REG_OVERTEMP_LIM: bus.rd_data = c_r.overtemp_lim;
			`REG_SLOW_FREQ: bus.rd_data = c_r.slow_freq;
			`REG_TEST_GPIO: bus.rd_data = c_r.test_gpio;
			`REG_STATUS2: bus.rd_data = status2;
			`REG_TEMP_CODE: bus.rd_data = c_r.temp_code;
			default: bus.rd_data = 8'h00;
		endcase
	end

	// outputs
	assign FAN_DRIVE = c_r.fan;
	assign FAST_FAN_DRIVE = !c_r.ext_cfg[`EXT_SLOW_BIT];
	assign MF_PIN_O = 1'b0;
	assign MF_PIN_OE = c_r.mf_oe;
	assign OVERTEMPERATURE_PIN_ASSERTED = c_r.ot_in;
	assign FAN4_SPEED_INPUT = c_r.f4_speed;
	assign MONITOR_EN = c_r.st != ST_WAIT;
	assign FAILSAFE = c_r.st == ST_FAILSAFE;
	assign TEMP_CODE = c_r.temp_code;

	////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RSTN);
	a_core_volt_start: assert property (CE && c_r.st == ST_WAIT
		&& CPU_CORE_VOLTAGE_INPUT |=> MONITOR_EN && !FAILSAFE)
		else $error("monitoring not started by core voltage");
	a_txn_start: assert property (CE && c_r.st == ST_WAIT
		&& !CPU_CORE_VOLTAGE_INPUT && bus.done |=> c_r.st == ST_NORMAL)
		else $error("monitoring not started by transaction");
	a_failsafe_timeout: assert property (CE && c_r.st == ST_TIMING
		&& !bus.addr_hit && c_r.timer == 30'(FS_CYCLES - 1) |=> FAILSAFE)
		else $error("fail-safe not entered at timeout");
	a_no_timeout_idle: assert property (c_r.st == ST_WAIT |-> !FAILSAFE && c_r.timer == 30'h0)
		else $error("fail-safe timing without core voltage");
	a_write_recovers: assert property (CE && FAILSAFE && bus.wr_stb |=> !FAILSAFE)
		else $error("write did not leave fail-safe");
	a_full_speed: assert property (CE && (FAILSAFE || c_r.over) |=> FAN_DRIVE[2:1] == 2'h3)
		else $error("fans not at full speed");
	a_duty_cap: assert property (CE && !full && c_r.max_duty != `FULL_DUTY
		&& c_r.drv_cnt >= c_r.max_duty |=> !FAN_DRIVE[1])
		else $error("duty above programmed maximum");
	a_cfg_write: assert property (CE && bus.wr_stb
		&& bus.wr_addr == `REG_EXT_CFG |=> c_r.ext_cfg == $past(bus.wr_data))
		else $error("configuration write not applied");
	a_xor_route: assert property (CE && c_r.test_gpio[`TEST_XOR_BIT]
		|=> FAN_DRIVE[0] == $past(XOR_TREE_OUTPUT))
		else $error("xor tree not on first drive");
	a_gpio_input: assert property (CE && pinf == `PINF_GPIO
		&& !c_r.ext_cfg[`GPIO_DIR_BIT] |=> !MF_PIN_OE)
		else $error("general pin driven while input");
	a_alert_drive: assert property (CE && pinf == `PINF_ALERT && ALERT_REQ |=> MF_PIN_OE)
		else $error("alert not driven");
	c_failsafe: cover property (c_r.st == ST_TIMING ##1 FAILSAFE);
	c_overtemp: cover property (c_r.over && !FAILSAFE);
	c_slow_tick: cover property (c_r.ext_cfg[`EXT_SLOW_BIT] && tick);
	c_gpio_out: cover property (pinf == `PINF_GPIO && MF_PIN_OE);
endmodule

// ### fan_monitor_cfg.svh
`ifndef FAN_MONITOR_CFG_SVH
`define FAN_MONITOR_CFG_SVH
// serial bus identity
`define SMB_DEV_ADDR 7'h2E
// register offsets
`define REG_EXT_CFG 8'h7C
`define REG_PIN_CFG 8'h7D
`define REG_TEMP_OFFSET 8'h70
`define REG_MAX_DUTY 8'h71
`define REG_OVERTEMP_LIM 8'h72
`define REG_SLOW_FREQ 8'h73
`define REG_TEST_GPIO 8'h74
`define REG_STATUS2 8'h75
`define REG_TEMP_CODE 8'h76
// reset values
`define EXT_CFG_RST 8'h01
`define PIN_CFG_RST 8'h00
`define TEMP_OFFSET_RST 8'h00
`define MAX_DUTY_RST 8'hFF
`define OVERTEMP_LIM_RST 8'hA4
`define SLOW_FREQ_RST 8'h01
`define TEST_GPIO_RST 8'h00
// field positions
`define EXT_RANGE_BIT 0
`define EXT_SLOW_BIT 1
`define GPIO_DIR_BIT 2
`define GPIO_POL_BIT 3
`define TEST_XOR_BIT 0
`define TEST_GPIO_OUT_BIT 1
`define STAT2_FAILSAFE_BIT 0
`define STAT2_OVERTEMP_BIT 1
`define STAT2_MONITOR_BIT 2
`define STAT2_SHARED_BIT 5
// pin function codes
`define PINF_FAN4 2'h0
`define PINF_OVERTEMP 2'h1
`define PINF_ALERT 2'h2
`define PINF_GPIO 2'h3
// temperature format and full duty value
`define TEMP_BIAS 10'h040
`define FULL_DUTY 8'hFF
// timing
`define CLK_FREQ_HZ 200000000
`define FAILSAFE_TIME_MS 4600
`define FAILSAFE_CYCLES (`FAILSAFE_TIME_MS * (`CLK_FREQ_HZ / 1000))
`define DRIVE_STEPS 256
`define FAST_DRIVE_HZ 22500
`define FAST_TICK_CYCLES (`CLK_FREQ_HZ / (`FAST_DRIVE_HZ * `DRIVE_STEPS))
`define SLOW_BASE_HZ 10
`define SLOW_ACC_LIMIT (`CLK_FREQ_HZ / (`SLOW_BASE_HZ * `DRIVE_STEPS))
`define SLOW_MULT_MAX 4'hA
`endif

// ### fan_monitor_pkg.sv
package fan_monitor_pkg;
	// start-up sequence
	typedef enum logic [3:0] {ST_WAIT = 4'h1, ST_TIMING = 4'h2, ST_NORMAL = 4'h4,
		ST_FAILSAFE = 4'h8} startup_t;
	// serial slave states
	typedef enum logic [6:0] {SB_IDLE = 7'h01, SB_DEVADDR = 7'h02, SB_ACKADDR = 7'h04,
		SB_RX = 7'h08, SB_ACKRX = 7'h10, SB_TX = 7'h20, SB_ACKTX = 7'h40} smb_state_t;
	typedef struct packed {
		smb_state_t st;
		logic [3:0] bitcnt;
		logic [7:0] shreg;
		logic rw;
		logic first;
		logic matched;
		logic [7:0] ptr;
		logic sda_oe;
		logic scl_q;
		logic sda_q;
		logic wr_stb;
		logic [7:0] wr_data;
		logic addr_hit;
		logic done;
	} smb_regs_t;
	typedef struct packed {
		startup_t st;
		logic [29:0] timer;
		logic [7:0] ext_cfg;
		logic [7:0] pin_cfg;
		logic [7:0] temp_offset;
		logic [7:0] max_duty;
		logic [7:0] overtemp_lim;
		logic [7:0] slow_freq;
		logic [7:0] test_gpio;
		logic [7:0] temp_code;
		logic over;
		logic [5:0] tick_cnt;
		logic [16:0] slow_acc;
		logic [7:0] drv_cnt;
		logic [2:0] fan;
		logic mf_oe;
		logic shared_stat;
		logic ot_in;
		logic f4_speed;
	} ctrl_regs_t;
endpackage

// ### smb_if.sv
interface smb_if;
	logic wr_stb; // one-cycle register write
	logic [7:0] wr_addr; // target of the write
	logic [7:0] wr_data; // byte being written
	logic [7:0] rd_ptr; // current address pointer
	logic [7:0] rd_data; // byte served to a read
	logic addr_hit; // pulse: device address matched
	logic done; // pulse: addressed transaction ended
	modport slave (output wr_stb, wr_addr, wr_data, rd_ptr, addr_hit, done, input rd_data);
	modport regs (input wr_stb, wr_addr, wr_data, rd_ptr, addr_hit, done, output rd_data);
endinterface

// ### smb_slave.sv
`include "fan_monitor_cfg.svh"
module smb_slave
	import fan_monitor_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	input wire logic ce,
	// serial pins
	input wire logic scl,
	input wire logic sda_i,
	output logic sda_oe,
	// register side
	smb_if.slave bus
);
	smb_regs_t r_r; // all slave state
	smb_regs_t r_nxt; // next state
	logic scl_rise, scl_fall, start_c, stop_c;

	////////////////////////////////////////////////////////////////////////////
	// bus conditions seen between two samples
	assign scl_rise = scl & ~r_r.scl_q;
	assign scl_fall = ~scl & r_r.scl_q;
	assign start_c = scl & r_r.scl_q & r_r.sda_q & ~sda_i;
	assign stop_c = scl & r_r.scl_q & ~r_r.sda_q & sda_i;

	// protocol engine
	always_comb
	begin
		r_nxt = r_r;
		r_nxt.scl_q = scl;
		r_nxt.sda_q = sda_i;
		r_nxt.wr_stb = 1'b0;
		r_nxt.addr_hit = 1'b0;
		r_nxt.done = 1'b0;
		if (start_c || stop_c)
		begin
			// a repeated start also closes the previous transaction
			r_nxt.done = r_r.matched;
			r_nxt.matched = 1'b0;
			r_nxt.sda_oe = 1'b0;
			r_nxt.bitcnt = 4'h0;
			r_nxt.first = 1'b1;
			r_nxt.st = start_c ? SB_DEVADDR : SB_IDLE;
		end
		else
		begin
			case (r_r.st)
				SB_DEVADDR, SB_RX:
				begin
					if (scl_rise)
					begin
						r_nxt.shreg = {r_r.shreg[6:0], sda_i};
						r_nxt.bitcnt = r_r.bitcnt + 4'h1;
					end
					else if (scl_fall && r_r.bitcnt == 4'h8)
					begin
						r_nxt.bitcnt = 4'h0;
						if (r_r.st == SB_DEVADDR)
						begin
							// fixed address only, others are left alone
							if (r_r.shreg[7:1] == `SMB_DEV_ADDR)
							begin
								r_nxt.sda_oe = 1'b1;
								r_nxt.rw = r_r.shreg[0];
								r_nxt.matched = 1'b1;
								r_nxt.addr_hit = 1'b1;
								r_nxt.st = SB_ACKADDR;
							end
							else
								r_nxt.st = SB_IDLE;
						end
						else
						begin
							r_nxt.sda_oe = 1'b1;
							r_nxt.st = SB_ACKRX;
							r_nxt.first = 1'b0;
							// first byte is the pointer, later ones are data
							if (r_r.first)
								r_nxt.ptr = r_r.shreg;
							else
							begin
								r_nxt.wr_stb = 1'b1;
								r_nxt.wr_data = r_r.shreg;
							end
						end
					end
				end
				SB_ACKADDR:
				begin
					if (scl_fall)
					begin
						r_nxt.bitcnt = 4'h0;
						if (r_r.rw)
						begin
							// open drain: drive low only for a zero bit
							r_nxt.shreg = bus.rd_data;
							r_nxt.sda_oe = ~bus.rd_data[7];
							r_nxt.st = SB_TX;
						end
						else
						begin
							r_nxt.sda_oe = 1'b0;
							r_nxt.st = SB_RX;
						end
					end
				end
				SB_ACKRX:
				begin
					if (scl_fall)
					begin
						r_nxt.sda_oe = 1'b0;
						r_nxt.st = SB_RX;
					end
				end
				SB_TX:
				begin
					if (scl_fall)
					begin
						if (r_r.bitcnt == 4'h7)
						begin
							r_nxt.sda_oe = 1'b0;
							r_nxt.st = SB_ACKTX;
						end
						else
						begin
							r_nxt.sda_oe = ~r_r.shreg[6];
							r_nxt.shreg = {r_r.shreg[6:0], 1'b0};
							r_nxt.bitcnt = r_r.bitcnt + 4'h1;
						end
					end
				end
				SB_ACKTX:
				begin
					// master ack asks for the same register again
					if (scl_rise)
						r_nxt.st = sda_i ? SB_IDLE : SB_ACKADDR;
				end
				default:
					r_nxt.st = SB_IDLE;
			endcase
		end
	end

	// state register
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			r_r <= '{st: SB_IDLE, first: 1'b1, scl_q: 1'b1, sda_q: 1'b1, default: '0};
		else if (ce)
			r_r <= r_nxt;
	end

	assign sda_oe = r_r.sda_oe;
	assign bus.wr_stb = r_r.wr_stb;
	assign bus.wr_addr = r_r.ptr;
	assign bus.wr_data = r_r.wr_data;
	assign bus.rd_ptr = r_r.ptr;
	assign bus.addr_hit = r_r.addr_hit;
	assign bus.done = r_r.done;

	////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	a_foreign_addr: assert property (ce && r_r.st == SB_DEVADDR && scl_fall
		&& !start_c && !stop_c && r_r.bitcnt == 4'h8 && r_r.shreg[7:1] != `SMB_DEV_ADDR
		|=> r_r.st == SB_IDLE && !r_r.addr_hit)
		else $error("foreign address was answered");
	a_pointer_first: assert property (ce && r_r.st == SB_RX && r_r.first
		&& scl_fall && !start_c && !stop_c && r_r.bitcnt == 4'h8
		|=> !r_r.wr_stb && r_r.ptr == $past(r_r.shreg))
		else $error("first write byte not taken as pointer");
endmodule

// ### smb_host.sv
// serial bus master standing in for the system controller
module smb_host
(
	// clock
	input wire logic clk,
	// bus lines
	input wire logic sda,
	output logic scl,
	output logic sda_pull
);
	timeunit 1ns;
	timeprecision 100ps;

	////////////////////////////////////////////////////////////////
	// idle bus: clock stands high, data released to the pull-up
	initial
	begin
		scl = 1'b1;
		sda_pull = 1'b0;
	end

	// quarter of a bit period, four system clocks
	task automatic q();
		repeat (4) @(posedge clk);
	endtask

	// one bit: data moves only while the clock is low
	task automatic bit_io(input logic b, output logic s);
		q();
		sda_pull <= ~b;
		q();
		scl <= 1'b1;
		q();
		q();
		s = sda;
		scl <= 1'b0;
	endtask

	// start: data falls while the clock is high
	task automatic start();
		q();
		sda_pull <= 1'b1;
		q();
		scl <= 1'b0;
	endtask

	// stop: data rises while the clock is high
	task automatic stop();
		q();
		sda_pull <= 1'b1;
		q();
		scl <= 1'b1;
		q();
		sda_pull <= 1'b0;
		q();
	endtask

	// one byte, msb first; ninth bit released, so a read ends in no-ack
	task automatic xfer(input logic [7:0] t, output logic [7:0] r, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
			bit_io(t[i], r[i]);
		bit_io(1'b1, s);
		ack = ~s;
	endtask
endmodule

// ### fan_monitor_tb.sv
module fan_monitor_tb;
	timeunit 1ns;
	timeprecision 100ps;
	// short fail-safe wait keeps the run brief
	localparam int FS = 2000;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic volt = 1'b0;
	logic xor_in = 1'b0;
	logic alert = 1'b0;
	logic f4_fault = 1'b0; // fan4 status seen in the shared bit
	logic [23:0] duty = 24'h000000; // automatic loop requests, three channels
	logic ext_pull = 1'b0; // far side pulling the shared pin low
	logic [9:0] temp = 10'h032; // 25 C in half degrees
	wire scl, sda_pull, sda_oe, mf_oe, sda, mf_i;
	wire fast_drv, ot_pin, f4_in, mon_en, failsafe;
	wire [2:0] fan;
	wire [7:0] tcode;
	logic [7:0] r;
	logic k;
	int failures = 0;
	int num_checks = 0;
	logic [2:0] exp_role [4] = '{3'h0, 3'h3, 3'h6, 3'h2}; // oe, fan4 copy, overtemp

	// open-drain lines with pull-ups
	assign sda = ~(sda_pull | sda_oe);
	assign mf_i = ~(mf_oe | ext_pull);

	always #2.5 clk = ~clk;

	smb_host i_host (.clk(clk), .sda(sda), .scl(scl), .sda_pull(sda_pull));

	fan_monitor #(.FS_CYCLES(FS), .SLOW_ACC_LIMIT(8)) i_dut (
		.CLK(clk), .RSTN(rstn), .CE(1'b1), .SCL(scl), .SDA_I(sda), .SDA_O(), .SDA_OE(sda_oe),
		.CPU_CORE_VOLTAGE_INPUT(volt), .TEMP_IN(temp), .DUTY_REQ(duty),
		.ALERT_REQ(alert), .FAN4_FAULT(f4_fault), .XOR_TREE_OUTPUT(xor_in), .FAN_DRIVE(fan),
		.FAST_FAN_DRIVE(fast_drv), .MF_PIN_I(mf_i), .MF_PIN_O(), .MF_PIN_OE(mf_oe),
		.OVERTEMPERATURE_PIN_ASSERTED(ot_pin), .FAN4_SPEED_INPUT(f4_in),
		.MONITOR_EN(mon_en), .FAILSAFE(failsafe), .TEMP_CODE(tcode));

	////////////////////////////////////////////////////////////////
	// verdict, reached from the main sequence or the watchdog
	task automatic report_and_stop();
		if (failures == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// single comparison point
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			failures++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// let n edges pass, then look once outputs have settled
	task automatic w(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// reset held eight cycles, core voltage set meanwhile
	task automatic do_reset(input logic v);
		@(posedge clk);
		rstn <= 1'b0;
		volt <= v;
		repeat (8) @(posedge clk);
		rstn <= 1'b1;
	endtask

	// write byte: address, pointer, data
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] x;
		logic a0, a1, a2;
		i_host.start();
		i_host.xfer(8'h5C, x, a0);
		i_host.xfer(a, x, a1);
		i_host.xfer(d, x, a2);
		i_host.stop();
		chk(8'({a0, a1, a2}), 8'h07);
		w(4);
	endtask

	// send byte to set the pointer, then receive byte
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		logic [7:0] x;
		logic ak;
		i_host.start();
		i_host.xfer(8'h5C, x, ak);
		i_host.xfer(a, x, ak);
		i_host.stop();
		i_host.start();
		i_host.xfer(8'h5D, x, ak);
		i_host.xfer(8'hFF, d, ak);
		i_host.stop();
		w(4);
	endtask

	////////////////////////////////////////////////////////////////
	// watchdog: far beyond the expected run length
	initial
	begin
		repeat (60000) @(posedge clk);
		failures++;
		report_and_stop();
	end

	////////////////////////////////////////////////////////////////
	// main sequence
	initial
	begin
		// no core voltage: idle until addressed
		do_reset(1'b0);
		w(20);
		chk(8'(mon_en), 8'h00);
		chk(8'(fast_drv), 8'h01);
		// another device's address gets no answer
		i_host.start();
		i_host.xfer(8'h5E, r, k);
		i_host.stop();
		w(4);
		chk(8'(k), 8'h00);
		chk(8'(mon_en), 8'h00);
		rd(8'h7C, r);
		chk(r, 8'h01);
		chk(8'(mon_en), 8'h01);
		rd(8'h7D, r);
		chk(r, 8'h00);
		// no timed fail-safe without core voltage
		w(FS + 50);
		chk(8'(failsafe), 8'h00);
		// drive frequency select
		wr(8'h7C, 8'h03);
		chk(8'(fast_drv), 8'h00);
		rd(8'h7C, r);
		chk(r, 8'h03);
		wr(8'h7C, 8'h01);
		chk(8'(fast_drv), 8'h01);
		// 25 C: extended biased, then legacy, then +10 C offset
		chk(tcode, 8'h59);
		wr(8'h7C, 8'h00);
		chk(tcode, 8'h19);
		wr(8'h70, 8'h14);
		chk(tcode, 8'h23);
		wr(8'h70, 8'h00);
		wr(8'h7C, 8'h01);
		// hot reading holds every drive fully on
		@(posedge clk) temp <= 10'h1FE;
		for (int i = 0; i < 3; i++)
		begin
			w(37);
			chk(8'(fan), 8'h07);
		end
		@(posedge clk) temp <= 10'h032;
		// loop asks for full duty: allowed at maximum FF, cut to nothing at cap 00
		@(posedge clk) duty <= 24'hFFFFFF;
		w(4);
		chk(8'(fan), 8'h07);
		wr(8'h71, 8'h00);
		chk(8'(fan), 8'h00);
		@(posedge clk) duty <= 24'h000000;
		// test mode routes the tree to the first drive
		wr(8'h74, 8'h01);
		for (int i = 0; i < 2; i++)
		begin
			@(posedge clk) xor_in <= i[0];
			w(4);
			chk(8'(fan[0]), 8'(i));
		end
		wr(8'h74, 8'h00);
		// every role of the shared pin, pin held low, alert pending
		@(posedge clk) ext_pull <= 1'b1;
		alert <= 1'b1;
		for (int i = 0; i < 4; i++)
		begin
			wr(8'h7D, 8'(i));
			chk(8'({mf_oe, f4_in, ot_pin}), 8'(exp_role[i]));
		end
		@(posedge clk) ext_pull <= 1'b0;
		wr(8'h7D, 8'h02);
		chk(8'(mf_oe), 8'h01);
		@(posedge clk) alert <= 1'b0;
		w(4);
		chk(8'(mf_oe), 8'h00);
		// fan4 role reports its fault in the shared status bit
		@(posedge clk) f4_fault <= 1'b1;
		wr(8'h7D, 8'h00);
		rd(8'h75, r);
		chk(r & 8'h20, 8'h20);
		@(posedge clk) f4_fault <= 1'b0;
		// general pin driving a 1, polarity and direction swept
		wr(8'h7D, 8'h03);
		wr(8'h74, 8'h02);
		wr(8'h7C, 8'h0D);
		chk(8'(mf_oe), 8'h00);
		wr(8'h7C, 8'h05);
		chk(8'(mf_oe), 8'h01);
		rd(8'h75, r);
		chk(r & 8'h20, 8'h20);
		wr(8'h7C, 8'h01);
		chk(8'(mf_oe), 8'h00);
		// core voltage present, bus silent: fail-safe
		do_reset(1'b1);
		w(3);
		chk(8'(mon_en), 8'h01);
		w(FS + 10);
		chk(8'({failsafe, fan}), 8'h0F);
		wr(8'h7C, 8'h03);
		chk(8'({failsafe, fast_drv}), 8'h00);
		// addressed in time: no fail-safe
		do_reset(1'b1);
		rd(8'h7C, r);
		w(FS + 10);
		chk(8'(failsafe), 8'h00);
		report_and_stop();
	end
endmodule
